// ===== hw/mae_pkg.sv
// constants for the motion alarm encoder
package mae_pkg;
   localparam logic [7:0] MAE_CODE_NONE      = 8'h00;
   localparam logic [7:0] MAE_CODE_STACK     = 8'h90;
   localparam logic [7:0] MAE_CODE_SEQ_REF   = 8'h94;
   localparam logic [7:0] MAE_CODE_CALC_OVF  = 8'h98;
   localparam logic [7:0] MAE_CODE_PAR_RANGE = 8'h99;
   localparam logic [7:0] MAE_CODE_ZERO_DIV  = 8'h9A;
   localparam logic [7:0] MAE_CODE_POS_WR    = 8'h9D;
   localparam logic [7:0] MAE_CODE_VAR_REF   = 8'h9E;
   localparam logic [7:0] MAE_CODE_PAR_WR    = 8'h9F;
   localparam logic [7:0] MAE_CODE_MOT_MOT   = 8'hA0;
   localparam logic [7:0] MAE_CODE_USER      = 8'hE0;
   localparam logic [7:0] MAE_CODE_LS_LOGIC  = 8'h60;
   localparam logic [7:0] MAE_CODE_LS_REV    = 8'h61;
   localparam logic [7:0] MAE_CODE_HOME_FAIL = 8'h62;
   localparam logic [7:0] MAE_CODE_HOME_NF   = 8'h63;
   localparam logic [7:0] MAE_CODE_TIM_SENS  = 8'h64;
   localparam logic [7:0] MAE_CODE_LS_OFFS   = 8'h6A;
   localparam logic [7:0] MAE_CODE_DRV_ALM   = 8'h6E;
   localparam logic [7:0] MAE_CODE_DRV_CONN  = 8'h6F;
   localparam logic [7:0] MAE_CODE_MOT_PAR   = 8'h70;
   localparam logic [3:0] MAE_BLINKS_SEQ     = 4'h1;
   localparam logic [3:0] MAE_BLINKS_MOTION  = 4'h7;
   // blink timing
   localparam int         MAE_CLK_MHZ        = 200;
   localparam int         MAE_ON_MS          = 200;
   localparam int         MAE_OFF_MS         = 200;
   localparam int         MAE_PAUSE_MS       = 1000;
   localparam int         MAE_ON_CYC   = MAE_ON_MS * 1000 * MAE_CLK_MHZ;
   localparam int         MAE_OFF_CYC  = MAE_OFF_MS * 1000 * MAE_CLK_MHZ;
   localparam int         MAE_PAUSE_CYC = MAE_PAUSE_MS * 1000 * MAE_CLK_MHZ;
   typedef enum logic [1:0] {
      MAE_IDLE  = 2'b00,
      MAE_ON    = 2'b01,
      MAE_OFF   = 2'b11,
      MAE_PAUSE = 2'b10
   } mae_blink_state_t;
endpackage

// ===== hw/mae_blink_if.sv
// blink request between alarm latch and led sequencer
`timescale 1ns/10ps
interface mae_blink_if;
   logic       active;
   logic [3:0] count;
   logic       led;
   modport latch (output active, output count, input led);
   modport blinker (input active, input count, output led);
endinterface

// ===== hw/mae_blinker.sv
// alarm led blink sequencer
`timescale 1ns/10ps
module mae_blinker
   import mae_pkg::*;
#(
   parameter int ON_CYC    = MAE_ON_CYC,
   parameter int OFF_CYC   = MAE_OFF_CYC,
   parameter int PAUSE_CYC = MAE_PAUSE_CYC
)(
   input  wire logic   clock_in,
   input  wire logic   resetn_in,
   mae_blink_if.blinker bl
);
   mae_blink_state_t state_r;
   logic [31:0]      timer_r;
   logic [3:0]       left_r;

   // repeat n pulses then a pause while alarm stands
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_r <= MAE_IDLE;
         timer_r <= 32'h0;
         left_r  <= 4'h0;
      end else if (!bl.active) begin
         state_r <= MAE_IDLE;
         timer_r <= 32'h0;
         left_r  <= 4'h0;
      end else begin
         unique case (state_r)
            MAE_IDLE: begin
               state_r <= MAE_ON;
               timer_r <= 32'(ON_CYC - 1);
               left_r  <= bl.count;
            end
            MAE_ON: begin
               if (timer_r == 32'h0) begin
                  left_r <= left_r - 4'h1;
                  if (left_r == 4'h1) begin
                     state_r <= MAE_PAUSE;
                     timer_r <= 32'(PAUSE_CYC - 1);
                  end else begin
                     state_r <= MAE_OFF;
                     timer_r <= 32'(OFF_CYC - 1);
                  end
               end else begin
                  timer_r <= timer_r - 32'h1;
               end
            end
            MAE_OFF: begin
               if (timer_r == 32'h0) begin
                  state_r <= MAE_ON;
                  timer_r <= 32'(ON_CYC - 1);
               end else begin
                  timer_r <= timer_r - 32'h1;
               end
            end
            MAE_PAUSE: begin
               if (timer_r == 32'h0) begin
                  state_r <= MAE_ON;
                  timer_r <= 32'(ON_CYC - 1);
                  left_r  <= bl.count;
               end else begin
                  timer_r <= timer_r - 32'h1;
               end
            end
         endcase
      end
   end

   // led drops in the same cycle as the alarm, not one cycle later
   assign bl.led = bl.active && (state_r == MAE_ON);
endmodule

// ===== hw/mae_alarm_encoder.sv
// alarm detection, latching and reporting for one motion axis
`timescale 1ns/10ps
// Behaviour
// - nesting stack exhausted raises 0x90; sequence group blinks once
// - calling a missing sequence raises 0x94
// - arithmetic overflow raises 0x98
// - out-of-range parameter assignment raises 0x99
// - divide by zero raises 0x9A
// - position counter write during motion raises 0x9D
// - reference to missing user variable raises 0x9E
// - forbidden parameter write raises 0x9F
// - motion start during incompatible motion raises 0xA0
// - raise-user-alarm command raises 0xE0
// - sequence and motion group alarms halt motion and sequence
// - both limits active raises 0x60; motion group blinks seven times
// - limit opposite seek direction during homing raises 0x61
// - unexpected limit transition during homing raises 0x62
// - homing spans both limits without home switch raises 0x63
// - missing sensor or timing position at home switch raises 0x64
// - limit during home offset move raises 0x6A
// - driver alarm input raises 0x6E
// - driver no-response cancels command and raises 0x6F
// - start with incompatible motion parameters raises 0x70
// - clear command, reset command or power cycle clears the alarm
// - alarm query returns the latched code
module mae_alarm_encoder
   import mae_pkg::*;
#(
   parameter int ON_CYC    = MAE_ON_CYC,
   parameter int OFF_CYC   = MAE_OFF_CYC,
   parameter int PAUSE_CYC = MAE_PAUSE_CYC
)(
   input  wire logic       clock_in,
   input  wire logic       resetn_in,
   input  wire logic       stack_exhausted_in,
   input  wire logic       missing_sequence_call_in,
   input  wire logic       calc_overflow_in,
   input  wire logic       param_out_of_range_in,
   input  wire logic       divide_by_zero_in,
   input  wire logic       position_counter_write_in,
   input  wire logic       missing_variable_ref_in,
   input  wire logic       param_write_forbidden_in,
   input  wire logic       raise_user_alarm_command_in,
   input  wire logic       clear_alarm_command_in,
   input  wire logic       reset_command_in,
   input  wire logic       alarm_query_command_in,
   input  wire logic       motion_start_req_in,
   input  wire logic       motion_incompatible_in,
   input  wire logic       motion_param_bad_in,
   input  wire logic       motion_active_flag_in,
   input  wire logic       limit_input_polarity_in,
   input  wire logic       limit_pos_in,
   input  wire logic       limit_neg_in,
   input  wire logic       home_seek_active_in,
   input  wire logic       home_seek_dir_pos_in,
   input  wire logic       home_offset_move_in,
   input  wire logic       home_switch_detect_in,
   input  wire logic       home_seek_type_needs_aux_in,
   input  wire logic       aux_sensor_in,
   input  wire logic       timing_position_in,
   input  wire logic       driver_alarm_in,
   input  wire logic       driver_timeout_in,
   output logic            motion_start_out,
   output logic            halt_motion_out,
   output logic            halt_sequence_out,
   output logic            cancel_command_out,
   output logic            alarm_active_out,
   output logic [7:0]      alarm_code_out,
   output logic            alarm_report_valid_out,
   output logic [7:0]      alarm_report_code_out,
   output logic            alarm_led_out
);
   logic [7:0] code_r;
   logic [7:0] code_nxt;
   logic       active_r;
   logic       report_valid_r;
   logic [7:0] report_code_r;
   logic       lim_pos;
   logic       lim_neg;
   logic       lim_pos_prev_r;
   logic       lim_neg_prev_r;
   logic       seen_pos_r;
   logic       seen_neg_r;
   logic       seen_home_r;
   logic       seek_prev_r;
   logic       motion_group;
   mae_blink_if bl ();

   // polarity selects normally open or normally closed sensors
   assign lim_pos = limit_pos_in ^ limit_input_polarity_in;
   assign lim_neg = limit_neg_in ^ limit_input_polarity_in;

   // homing progress tracking for the span and transition checks
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         lim_pos_prev_r <= 1'b0;
         lim_neg_prev_r <= 1'b0;
         seen_pos_r     <= 1'b0;
         seen_neg_r     <= 1'b0;
         seen_home_r    <= 1'b0;
         seek_prev_r    <= 1'b0;
      end else begin
         lim_pos_prev_r <= lim_pos;
         lim_neg_prev_r <= lim_neg;
         seek_prev_r    <= home_seek_active_in;
         // a limit already present in the first seek cycle counts as seen
         if (!home_seek_active_in) begin
            seen_pos_r  <= 1'b0;
            seen_neg_r  <= 1'b0;
            seen_home_r <= 1'b0;
         end else begin
            seen_pos_r  <= seen_pos_r | lim_pos;
            seen_neg_r  <= seen_neg_r | lim_neg;
            seen_home_r <= seen_home_r | home_switch_detect_in;
         end
      end
   end

   // priority order: motion group first, then sequence group
   always_comb begin
      code_nxt = MAE_CODE_NONE;
      if (lim_pos && lim_neg)
         code_nxt = MAE_CODE_LS_LOGIC;
      else if (home_seek_active_in &&
               ((home_seek_dir_pos_in && lim_neg && !lim_neg_prev_r) ||
                (!home_seek_dir_pos_in && lim_pos && !lim_pos_prev_r)))
         code_nxt = MAE_CODE_LS_REV;
      else if (home_seek_active_in && seek_prev_r &&
               ((lim_pos && !lim_pos_prev_r && seen_pos_r) ||
                (lim_neg && !lim_neg_prev_r && seen_neg_r)))
         code_nxt = MAE_CODE_HOME_FAIL;
      else if (home_seek_active_in && seen_pos_r && seen_neg_r &&
               !seen_home_r && !home_switch_detect_in)
         code_nxt = MAE_CODE_HOME_NF;
      else if (home_seek_active_in && home_switch_detect_in &&
               home_seek_type_needs_aux_in &&
               !(aux_sensor_in && timing_position_in))
         code_nxt = MAE_CODE_TIM_SENS;
      else if (home_offset_move_in && (lim_pos || lim_neg))
         code_nxt = MAE_CODE_LS_OFFS;
      else if (driver_alarm_in)
         code_nxt = MAE_CODE_DRV_ALM;
      else if (driver_timeout_in)
         code_nxt = MAE_CODE_DRV_CONN;
      else if (motion_start_req_in && motion_param_bad_in)
         code_nxt = MAE_CODE_MOT_PAR;
      else if (stack_exhausted_in)
         code_nxt = MAE_CODE_STACK;
      else if (missing_sequence_call_in)
         code_nxt = MAE_CODE_SEQ_REF;
      else if (calc_overflow_in)
         code_nxt = MAE_CODE_CALC_OVF;
      else if (param_out_of_range_in)
         code_nxt = MAE_CODE_PAR_RANGE;
      else if (divide_by_zero_in)
         code_nxt = MAE_CODE_ZERO_DIV;
      else if (position_counter_write_in && motion_active_flag_in)
         code_nxt = MAE_CODE_POS_WR;
      else if (missing_variable_ref_in)
         code_nxt = MAE_CODE_VAR_REF;
      else if (param_write_forbidden_in)
         code_nxt = MAE_CODE_PAR_WR;
      else if (motion_start_req_in && motion_incompatible_in)
         code_nxt = MAE_CODE_MOT_MOT;
      else if (raise_user_alarm_command_in)
         code_nxt = MAE_CODE_USER;
   end

   // first alarm wins; a new event in the clear cycle is kept
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         code_r   <= MAE_CODE_NONE;
         active_r <= 1'b0;
      end else if (!active_r && code_nxt != MAE_CODE_NONE) begin
         code_r   <= code_nxt;
         active_r <= 1'b1;
      end else if (active_r &&
                   (clear_alarm_command_in || reset_command_in)) begin
         code_r   <= code_nxt;
         active_r <= (code_nxt != MAE_CODE_NONE);
      end
   end

   // query answer, one cycle after the request
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         report_valid_r <= 1'b0;
         report_code_r  <= MAE_CODE_NONE;
      end else begin
         report_valid_r <= alarm_query_command_in;
         if (alarm_query_command_in)
            report_code_r <= code_r;
      end
   end

   assign motion_group = (code_r[7:4] == MAE_CODE_LS_LOGIC[7:4]) ||
                         (code_r == MAE_CODE_MOT_PAR);
   assign bl.active = active_r;
   assign bl.count  = motion_group ? MAE_BLINKS_MOTION
                                   : MAE_BLINKS_SEQ;

   mae_blinker #(
      .ON_CYC    (ON_CYC),
      .OFF_CYC   (OFF_CYC),
      .PAUSE_CYC (PAUSE_CYC)
   ) u_blinker (
      .clock_in  (clock_in),
      .resetn_in (resetn_in),
      .bl        (bl)
   );

   assign halt_motion_out   = active_r;
   assign halt_sequence_out = active_r;
   assign cancel_command_out = driver_timeout_in;
   assign motion_start_out  = motion_start_req_in && !active_r &&
                              (code_nxt == MAE_CODE_NONE);
   assign alarm_active_out       = active_r;
   assign alarm_code_out         = code_r;
   assign alarm_report_valid_out = report_valid_r;
   assign alarm_report_code_out  = report_code_r;
   assign alarm_led_out          = bl.led;
endmodule

// ===== testbench/mae_alarm_encoder_sva.sv
// assertion checker for the motion alarm encoder
`timescale 1ns/10ps
module mae_alarm_encoder_sva
   import mae_pkg::*;
(
   input wire logic       clock_in,
   input wire logic       resetn_in,
   input wire logic       clear_alarm_command_in,
   input wire logic       reset_command_in,
   input wire logic       alarm_query_command_in,
   input wire logic       motion_start_req_in,
   input wire logic       motion_incompatible_in,
   input wire logic       motion_param_bad_in,
   input wire logic       limit_input_polarity_in,
   input wire logic       limit_pos_in,
   input wire logic       limit_neg_in,
   input wire logic       driver_timeout_in,
   input wire logic       motion_start_out,
   input wire logic       halt_motion_out,
   input wire logic       halt_sequence_out,
   input wire logic       cancel_command_out,
   input wire logic       alarm_active_out,
   input wire logic [7:0] alarm_code_out,
   input wire logic       alarm_report_valid_out,
   input wire logic [7:0] alarm_report_code_out,
   input wire logic       alarm_led_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!resetn_in);
   sequence s_both_limits;
      !alarm_active_out && (limit_pos_in ^ limit_input_polarity_in) &&
      (limit_neg_in ^ limit_input_polarity_in);
   endsequence
   sequence s_held;
      alarm_active_out && !clear_alarm_command_in && !reset_command_in;
   endsequence
   AST_LS_LOGIC: assert property (s_both_limits |=>
      alarm_active_out && alarm_code_out == MAE_CODE_LS_LOGIC)
      else $error("both limits did not latch their code");
   AST_HOLD: assert property (s_held |=>
      alarm_active_out && $stable(alarm_code_out))
      else $error("latched code changed without a clear");
   AST_REPORT: assert property (alarm_query_command_in |=>
      alarm_report_valid_out && alarm_report_code_out == $past(alarm_code_out))
      else $error("query report wrong");
   AST_REPORT_PULSE: assert property (alarm_report_valid_out |->
      $past(alarm_query_command_in))
      else $error("report without query");
   AST_START: assert property (motion_start_out |->
      motion_start_req_in && !motion_incompatible_in &&
      !motion_param_bad_in && !alarm_active_out)
      else $error("start passed while refused");
   AST_HALT: assert property (alarm_active_out |->
      halt_motion_out && halt_sequence_out)
      else $error("alarm without halt");
   AST_CANCEL: assert property (cancel_command_out == driver_timeout_in)
      else $error("cancel does not follow driver silence");
   AST_IDLE: assert property (!alarm_active_out |->
      alarm_code_out == 8'h00 && !alarm_led_out)
      else $error("code or led shown while idle");
endmodule
bind mae_alarm_encoder mae_alarm_encoder_sva u_sva (.*);

// ===== testbench/mae_sensor_model.sv
// limit, home switch and motor driver model
`timescale 1ns/10ps
module mae_sensor_model (
   input  wire logic pos_hit_in,
   input  wire logic neg_hit_in,
   input  wire logic home_hit_in,
   input  wire logic polarity_in,
   input  wire logic fault_in,
   input  wire logic silent_in,
   output logic      limit_pos_out,
   output logic      limit_neg_out,
   output logic      home_switch_out,
   output logic      driver_alarm_out,
   output logic      driver_timeout_out
);
   // active-low wiring inverts the idle level
   assign limit_pos_out      = pos_hit_in ^ polarity_in;
   assign limit_neg_out      = neg_hit_in ^ polarity_in;
   assign home_switch_out    = home_hit_in;
   assign driver_alarm_out   = fault_in;
   assign driver_timeout_out = silent_in;
endmodule

// ===== testbench/motion_alarm_encoder_tb.sv
// self-checking bench for the motion alarm encoder
`timescale 1ns/10ps
module motion_alarm_encoder_tb;
   import mae_pkg::*;
   logic        clk, rstn, mact, pol, seek, dirp, offs, naux, aux, tim;
   logic        pos_h, neg_h, home_h, clr, rcmd, qry, start;
   logic        lpos, lneg, hsw, dalm, dto, m_st, h_m, h_s, canc, act, rv, led;
   logic [13:0] cause;
   logic [7:0]  code, rcode;
   int          err_count, comparisons;
   localparam logic [7:0] CODES [14] = '{MAE_CODE_STACK, MAE_CODE_SEQ_REF,
      MAE_CODE_CALC_OVF, MAE_CODE_PAR_RANGE, MAE_CODE_ZERO_DIV,
      MAE_CODE_POS_WR, MAE_CODE_VAR_REF, MAE_CODE_PAR_WR, MAE_CODE_USER,
      MAE_CODE_MOT_MOT, MAE_CODE_MOT_PAR, MAE_CODE_DRV_ALM,
      MAE_CODE_DRV_CONN, MAE_CODE_LS_LOGIC};
   mae_sensor_model sensors (.pos_hit_in(pos_h | cause[13]),
      .neg_hit_in(neg_h | cause[13]), .home_hit_in(home_h),
      .polarity_in(pol), .fault_in(cause[11]), .silent_in(cause[12]),
      .limit_pos_out(lpos), .limit_neg_out(lneg), .home_switch_out(hsw),
      .driver_alarm_out(dalm), .driver_timeout_out(dto));
   mae_alarm_encoder #(.ON_CYC(4), .OFF_CYC(4), .PAUSE_CYC(10)) dut (
      .clock_in(clk), .resetn_in(rstn), .stack_exhausted_in(cause[0]),
      .missing_sequence_call_in(cause[1]), .calc_overflow_in(cause[2]),
      .param_out_of_range_in(cause[3]), .divide_by_zero_in(cause[4]),
      .position_counter_write_in(cause[5]),
      .missing_variable_ref_in(cause[6]),
      .param_write_forbidden_in(cause[7]),
      .raise_user_alarm_command_in(cause[8]), .clear_alarm_command_in(clr),
      .reset_command_in(rcmd), .alarm_query_command_in(qry),
      .motion_start_req_in(start), .motion_incompatible_in(cause[9]),
      .motion_param_bad_in(cause[10]), .motion_active_flag_in(mact),
      .limit_input_polarity_in(pol), .limit_pos_in(lpos),
      .limit_neg_in(lneg), .home_seek_active_in(seek),
      .home_seek_dir_pos_in(dirp), .home_offset_move_in(offs),
      .home_switch_detect_in(hsw), .home_seek_type_needs_aux_in(naux),
      .aux_sensor_in(aux), .timing_position_in(tim), .driver_alarm_in(dalm),
      .driver_timeout_in(dto), .motion_start_out(m_st), .halt_motion_out(h_m),
      .halt_sequence_out(h_s), .cancel_command_out(canc),
      .alarm_active_out(act), .alarm_code_out(code),
      .alarm_report_valid_out(rv), .alarm_report_code_out(rcode),
      .alarm_led_out(led));
   task automatic chk1(input string n, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic chk8(input string n, input logic [7:0] e,
                       input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic got(input logic [7:0] e);
      @(posedge clk) #1;
      chk8("code", e, code);
      chk1("halt", 1'b1, h_m & h_s);
   endtask
   // drop every cause, then clear or reset-command at the same edge
   task automatic clear_all(input logic r);
      @(posedge clk);
      {cause, mact, pol, seek, dirp, offs, naux, pos_h, neg_h, home_h} <= '0;
      {start, rcmd, clr} <= {1'b0, r, !r};
      @(posedge clk);
      {rcmd, clr} <= 2'b00;
      #1 chk1("active", 1'b0, act);
   endtask
   task automatic t_codes();
      for (int i = 0; i < 14; i++) begin
         @(posedge clk);
         cause <= 14'h0001 << i;
         mact <= (i == 5);
         start <= (i == 9 || i == 10);
         #1 chk1("cancel", i == 12, canc);
         chk1("start", 1'b0, m_st);
         got(CODES[i]);
         @(posedge clk) qry <= 1'b1;
         @(posedge clk) qry <= 1'b0;
         #1 chk8("report", CODES[i], rv ? rcode : 8'hFF);
         clear_all(i[0]);
      end
   endtask
   task automatic t_order();
      @(posedge clk) start <= 1'b1;
      #1 chk1("start", 1'b1, m_st);
      @(posedge clk) cause <= 14'h0011;
      got(MAE_CODE_STACK);
      chk1("start", 1'b0, m_st);
      @(posedge clk) cause <= 14'h0100;
      got(MAE_CODE_STACK);
      @(posedge clk) clr <= 1'b1;
      got(MAE_CODE_USER);
      clear_all(1'b1);
   endtask
   task automatic t_led(input logic [13:0] c, input logic [7:0] n);
      logic [7:0] r;
      logic       p;
      @(posedge clk) cause <= c;
      for (int k = 0; k < 20 && led !== 1'b1; k++) @(posedge clk) #1;
      p = 1'b1;
      r = 8'h01;
      repeat (n * 8 + 2) begin
         @(posedge clk) #1;
         if (led === 1'b1 && !p) r++;
         p = led;
      end
      chk8("blinks", n, r);
      clear_all(1'b0);
   endtask
   task automatic t_home();
      @(posedge clk) {pol, seek, dirp, neg_h} <= 4'hF;
      got(MAE_CODE_LS_REV);
      clear_all(1'b0);
      @(posedge clk) {seek, dirp, pos_h} <= 3'h7;
      @(posedge clk) pos_h <= 1'b0;
      @(posedge clk) pos_h <= 1'b1;
      got(MAE_CODE_HOME_FAIL);
      clear_all(1'b0);
      @(posedge clk) {seek, dirp, pos_h} <= 3'h7;
      @(posedge clk) {dirp, pos_h} <= 2'b00;
      @(posedge clk) neg_h <= 1'b1;
      @(posedge clk);
      got(MAE_CODE_HOME_NF);
      clear_all(1'b0);
      @(posedge clk) {seek, naux, home_h, aux, tim} <= 5'h1F;
      @(posedge clk) #1 chk1("active", 1'b0, act);
      @(posedge clk) {aux, tim} <= 2'b00;
      got(MAE_CODE_TIM_SENS);
      clear_all(1'b0);
      @(posedge clk) {offs, pos_h} <= 2'b11;
      got(MAE_CODE_LS_OFFS);
      clear_all(1'b1);
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      {rstn, mact, pol, seek, dirp, offs, naux, aux, tim} = '0;
      {pos_h, neg_h, home_h, clr, rcmd, qry, start, cause} = '0;
      err_count = 0;
      comparisons = 0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      t_codes();
      $display("codes test done");
      t_order();
      $display("order test done");
      t_led(14'h0010, 8'h01);
      t_led(14'h2000, 8'h07);
      $display("blink test done");
      t_home();
      $display("homing test done");
      close_out();
   end
   initial begin
      #50000;
      err_count++;
      close_out();
   end
endmodule
